// ===== shared/level_pkg.sv
// Constants, register map and types for the level sensor mode controller.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package level_pkg;

   // Clock and time base
   localparam longint CLK_HZ = 125_000_000;
   localparam longint WAKE_TIME_S = 60;
   localparam longint CAL_SLOW_S = 60;
   localparam longint CAL_FAST_S = 1;
   localparam longint WAKE_CYCLES = CLK_HZ * WAKE_TIME_S;
   localparam longint CAL_SLOW_CYCLES = CLK_HZ * CAL_SLOW_S;
   localparam longint CAL_FAST_CYCLES = CLK_HZ * CAL_FAST_S;
   localparam int TMR_W = 36;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ZONE_MIN_OFS = 8'h04;
   localparam logic [7:0] ZONE_MAX_OFS = 8'h08;
   localparam logic [7:0] HEIGHT_OFS = 8'h0c;
   localparam logic [7:0] IDS_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] LEVEL_OFS = 8'h18;
   localparam logic [7:0] DIST_OFS = 8'h1c;
   localparam logic [7:0] P2P_BAUD_OFS = 8'h20;
   localparam logic [7:0] BUS_BAUD_OFS = 8'h24;
   localparam logic [7:0] FRAME_OFS = 8'h28;

   // CTRL field positions
   localparam int CTRL_OPER_BIT = 0;
   localparam int CTRL_SDI_BIT = 1;
   localparam int CTRL_FCAL_BIT = 2;
   localparam int CTRL_FRST_BIT = 3;
   localparam int CTRL_UNIT_LSB = 4;

   // Parity codes for the framing fields
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;

   // Values after reset
   localparam logic [3:0] UNIT_MM = 4'h0;
   localparam logic [31:0] ZONE_MIN_RST = 32'h0000_0000;
   localparam logic [31:0] ZONE_MAX_RST = 32'h0000_3a98;
   localparam logic [31:0] HEIGHT_RST = 32'h0000_0000;
   localparam logic [7:0] BUS_ID_RST = 8'h01;
   localparam logic [7:0] SDI_ID_RST = 8'h30;
   localparam logic [31:0] P2P_BAUD_RST = 32'd115200;
   localparam logic [31:0] BUS_BAUD_RST = 32'd9600;
   localparam logic [3:0] DATA_BITS_RST = 4'h8;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Mode settings that are applied only between measurements
   typedef struct packed {
      logic operating;
      logic sdi_mode;
      logic force_cal;
      logic [3:0] unit;
   } mode_t;

   localparam mode_t MODE_RST = '{operating: 1'b1, sdi_mode: 1'b0, force_cal: 1'b0,
                                  unit: UNIT_MM};

   // Serial framing handed to the line engines
   typedef struct packed {
      logic [31:0] baud;
      logic [3:0] data_bits;
      logic [1:0] parity;
      logic two_stop;
   } frame_t;

   localparam frame_t P2P_FRAME_RST = '{baud: P2P_BAUD_RST, data_bits: DATA_BITS_RST,
                                       parity: PAR_NONE, two_stop: 1'b0};
   localparam frame_t BUS_FRAME_RST = '{baud: BUS_BAUD_RST, data_bits: DATA_BITS_RST,
                                       parity: PAR_EVEN, two_stop: 1'b0};

   typedef enum logic [1:0] {ST_IDLE, ST_CAL, ST_MEAS} seq_t;

endpackage

// ===== logic/level_sensor_mode_control.sv
// Measurement sequencing, power modes and level conversion for a radar level sensor.
// Assumes a radar front end on the same clock and serial line engines that use
// the framing outputs; all inputs are synchronous to aclk.
// Summary of operation
// - Accept echoes only inside the active zone.
// - Level equals sensor height minus distance.
// - Standby keeps links alive, no measuring.
// - Operating mode measures back to back.
// - Continuous mode pushes each result, latches latest.
// - SDI-12 mode sleeps until addressed measure; due calibrations still start while asleep.
// - Asleep, ignore bus and point-to-point links.
// - One minute wake window after power-up.
// - Factory reset completes after power cycle.
// - Calibrate at power-up, then every minute.
// - Forced calibration repeats every second.
// - Point-to-point default 115200, 8N1.
// - Bus default 9600, 8E1.
// - Bus sends only in reply to requests.
// - Level unit defaults to millimetres.
// - Answer bus requests with matching identifier only.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module level_sensor_mode_control
   import level_pkg::*;
#(
   parameter longint WAKE_CYC = WAKE_CYCLES,
   parameter longint CAL_SLOW_CYC = CAL_SLOW_CYCLES,
   parameter longint CAL_FAST_CYC = CAL_FAST_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Radar front end
   output logic meas_start,
   output logic cal_start,
   input wire logic meas_done,
   input wire logic echo_found,
   input wire logic [31:0] echo_dist,
   input wire logic cal_done,
   // SDI-12 command decoder
   input wire logic sdi_measure,
   input wire logic [7:0] sdi_addr,
   // Point-to-point link
   input wire logic p2p_connect,
   output logic p2p_enable,
   output logic p2p_valid,
   input wire logic p2p_ready,
   output logic [31:0] p2p_level,
   output frame_t p2p_frame,
   // Multi-drop bus
   input wire logic bus_req,
   input wire logic [7:0] bus_req_addr,
   output logic bus_enable,
   output logic bus_reply,
   output logic [31:0] bus_level,
   output frame_t bus_frame,
   // Status
   output logic asleep,
   output logic [3:0] level_unit,
   output logic defaults_pending
);

   mode_t mode_r;
   mode_t mode_act_r;
   logic [31:0] zone_min_r;
   logic [31:0] zone_max_r;
   logic [31:0] height_r;
   logic [7:0] bus_id_r;
   logic [7:0] sdi_id_r;
   frame_t p2p_cfg_r;
   frame_t bus_cfg_r;
   logic frst_r;
   seq_t st_r;
   logic [TMR_W-1:0] cal_tmr_r;
   logic cal_due_r;
   logic [TMR_W-1:0] wake_tmr_r;
   logic awake_r;
   logic sdi_trig_r;
   logic [31:0] level_r;
   logic [31:0] dist_r;
   logic p2p_valid_r;
   logic bus_reply_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_go;
   logic rd_go;
   logic in_zone;
   logic cal_wrap;
   logic [TMR_W-1:0] cal_limit;

   // Merges a write into a register under its byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= FRAME_OFS);
   endfunction

   // Address and data are taken together; one write in flight at a time
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign rd_go = s_axi_arvalid && !rvalid_r;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Software-visible configuration
   // unit resets to millimetres
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= MODE_RST;
         zone_min_r <= ZONE_MIN_RST;
         zone_max_r <= ZONE_MAX_RST;
         height_r <= HEIGHT_RST;
         bus_id_r <= BUS_ID_RST;
         sdi_id_r <= SDI_ID_RST;
         p2p_cfg_r <= P2P_FRAME_RST;
         bus_cfg_r <= BUS_FRAME_RST;
         frst_r <= 1'b0;
      end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == CTRL_OFS &&
                   s_axi_wdata[CTRL_FRST_BIT]) begin
         // stored settings revert, links keep old framing
         mode_r <= MODE_RST;
         zone_min_r <= ZONE_MIN_RST;
         zone_max_r <= ZONE_MAX_RST;
         height_r <= HEIGHT_RST;
         bus_id_r <= BUS_ID_RST;
         sdi_id_r <= SDI_ID_RST;
         frst_r <= 1'b1;
      end else if (wr_go) begin
         unique case (s_axi_awaddr)
            CTRL_OFS: begin
               if (s_axi_wstrb[0]) begin
                  mode_r.operating <= s_axi_wdata[CTRL_OPER_BIT];
                  mode_r.sdi_mode <= s_axi_wdata[CTRL_SDI_BIT];
                  mode_r.force_cal <= s_axi_wdata[CTRL_FCAL_BIT];
                  mode_r.unit <= s_axi_wdata[CTRL_UNIT_LSB +: 4];
               end
            end
            ZONE_MIN_OFS: zone_min_r <= merge(zone_min_r, s_axi_wdata, s_axi_wstrb);
            ZONE_MAX_OFS: zone_max_r <= merge(zone_max_r, s_axi_wdata, s_axi_wstrb);
            HEIGHT_OFS: height_r <= merge(height_r, s_axi_wdata, s_axi_wstrb);
            IDS_OFS: begin
               if (s_axi_wstrb[0]) begin
                  bus_id_r <= s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  sdi_id_r <= s_axi_wdata[15:8];
               end
            end
            P2P_BAUD_OFS: begin
               if (!frst_r) begin
                  p2p_cfg_r.baud <= merge(p2p_cfg_r.baud, s_axi_wdata, s_axi_wstrb);
               end
            end
            BUS_BAUD_OFS: begin
               if (!frst_r) begin
                  bus_cfg_r.baud <= merge(bus_cfg_r.baud, s_axi_wdata, s_axi_wstrb);
               end
            end
            FRAME_OFS: begin
               if (!frst_r && s_axi_wstrb[0]) begin
                  bus_cfg_r.parity <= s_axi_wdata[1:0];
                  bus_cfg_r.two_stop <= s_axi_wdata[2];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read path answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            CTRL_OFS: rdata_r <= {24'h000000, mode_r.unit, 1'b0, mode_r.force_cal,
                                  mode_r.sdi_mode, mode_r.operating};
            ZONE_MIN_OFS: rdata_r <= zone_min_r;
            ZONE_MAX_OFS: rdata_r <= zone_max_r;
            HEIGHT_OFS: rdata_r <= height_r;
            IDS_OFS: rdata_r <= {16'h0000, sdi_id_r, bus_id_r};
            STATUS_OFS: rdata_r <= {26'h0000000, mode_act_r.operating, mode_act_r.sdi_mode,
                                    frst_r, awake_r, st_r == ST_CAL, st_r == ST_MEAS};
            LEVEL_OFS: rdata_r <= level_r;
            DIST_OFS: rdata_r <= dist_r;
            P2P_BAUD_OFS: rdata_r <= p2p_cfg_r.baud;
            BUS_BAUD_OFS: rdata_r <= bus_cfg_r.baud;
            FRAME_OFS: rdata_r <= {29'h00000000, bus_cfg_r.two_stop, bus_cfg_r.parity};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_act_r <= MODE_RST;
      end else if (st_r == ST_IDLE) begin
         mode_act_r <= mode_r;
      end
   end

   assign cal_limit = mode_act_r.force_cal ? TMR_W'(CAL_FAST_CYC - 1) :
                                             TMR_W'(CAL_SLOW_CYC - 1);
   assign cal_wrap = cal_tmr_r >= cal_limit;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_tmr_r <= '0;
         cal_due_r <= 1'b1;
      end else begin
         if (cal_wrap) begin
            cal_tmr_r <= '0;
         end else begin
            cal_tmr_r <= cal_tmr_r + 1'b1;
         end
         if (cal_wrap && mode_act_r.operating) begin
            cal_due_r <= 1'b1;
         end else if (st_r == ST_CAL && cal_done) begin
            cal_due_r <= 1'b0;
         end
      end
   end

   // wake window, restarted by a connection attempt made while still awake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_tmr_r <= '0;
         awake_r <= 1'b1;
      end else if (!mode_act_r.sdi_mode || (awake_r && p2p_connect)) begin
         wake_tmr_r <= '0;
         awake_r <= 1'b1;
      end else if (awake_r) begin
         if (wake_tmr_r >= TMR_W'(WAKE_CYC - 1)) begin
            awake_r <= 1'b0;
         end
         wake_tmr_r <= wake_tmr_r + 1'b1;
      end
   end

   // only an addressed measure starts a measurement in a sleeping unit; due calibrations still start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sdi_trig_r <= 1'b0;
      end else if (sdi_measure && sdi_addr == sdi_id_r) begin
         sdi_trig_r <= 1'b1;
      end else if (st_r == ST_MEAS && meas_done) begin
         sdi_trig_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_IDLE;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               if (cal_due_r && (mode_act_r.operating || sdi_trig_r)) begin
                  st_r <= ST_CAL;
               end else if (mode_act_r.operating &&
                            (!mode_act_r.sdi_mode || sdi_trig_r)) begin
                  st_r <= ST_MEAS;
               end
            end
            ST_CAL: begin
               if (cal_done) begin
                  st_r <= ST_IDLE;
               end
            end
            ST_MEAS: begin
               if (meas_done) begin
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   assign meas_start = st_r == ST_IDLE && !cal_due_r && mode_act_r.operating &&
                       (!mode_act_r.sdi_mode || sdi_trig_r);
   assign cal_start = st_r == ST_IDLE && cal_due_r && (mode_act_r.operating || sdi_trig_r);

   // echo must lie in the active zone
   assign in_zone = echo_found && echo_dist >= zone_min_r && echo_dist <= zone_max_r;

   // latest result held for polled links
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_r <= 32'h0000_0000;
         dist_r <= 32'h0000_0000;
      end else if (st_r == ST_MEAS && meas_done && in_zone) begin
         level_r <= height_r - echo_dist;
         dist_r <= echo_dist;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p2p_valid_r <= 1'b0;
      end else if (st_r == ST_MEAS && meas_done && in_zone && !mode_act_r.sdi_mode) begin
         p2p_valid_r <= 1'b1;
      end else if (p2p_ready) begin
         p2p_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_reply_r <= 1'b0;
      end else begin
         bus_reply_r <= bus_req && awake_r && bus_req_addr == bus_id_r;
      end
   end

   assign p2p_enable = awake_r;
   assign bus_enable = awake_r;
   assign p2p_valid = p2p_valid_r && awake_r;
   assign p2p_level = level_r;
   assign bus_reply = bus_reply_r;
   assign bus_level = level_r;
   assign asleep = !awake_r;
   assign level_unit = mode_act_r.unit;
   assign defaults_pending = frst_r;
   assign p2p_frame = p2p_cfg_r;
   assign bus_frame = bus_cfg_r;

endmodule

// ===== sim/level_sensor_mode_control_props.sv
// Port-level checks for the level sensor mode controller.
// Bound to the top module from the bench; one clock domain.
`timescale 1ns/1ps
module level_sensor_mode_control_props
   import level_pkg::*;
#(
   parameter longint WAKE_CYC = WAKE_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   // Front end and links
   input wire logic meas_start,
   input wire logic cal_start,
   input wire logic meas_done,
   input wire logic echo_found,
   input wire logic p2p_connect,
   input wire logic p2p_enable,
   input wire logic p2p_valid,
   input wire logic p2p_ready,
   input wire frame_t p2p_frame,
   input wire logic bus_req,
   input wire logic bus_enable,
   input wire logic bus_reply,
   input wire frame_t bus_frame,
   // Status
   input wire logic asleep,
   input wire logic defaults_pending
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic frst_wr;
   longint awake_cnt_r;
   assign frst_wr = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wstrb[0]
      && s_axi_awaddr == CTRL_OFS && s_axi_wdata[CTRL_FRST_BIT];
   // Cycles since power-up or the last accepted connect, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn || (p2p_connect && p2p_enable)) begin
         awake_cnt_r <= 0;
      end else if (awake_cnt_r < WAKE_CYC) begin
         awake_cnt_r <= awake_cnt_r + 1;
      end
   end
   property p_boot_cal;
      $rose(aresetn) |-> cal_start;
   endproperty
   a_boot_cal: assert property (p_boot_cal)
      else $error("no calibration after reset");
   property p_frame_p2p;
      $rose(aresetn) |-> p2p_frame == P2P_FRAME_RST;
   endproperty
   a_frame_p2p: assert property (p_frame_p2p)
      else $error("point-to-point framing not default");
   property p_frame_bus;
      $rose(aresetn) |-> bus_frame == BUS_FRAME_RST && !defaults_pending;
   endproperty
   a_frame_bus: assert property (p_frame_bus)
      else $error("bus framing not default");
   property p_sleep_quiet;
      asleep |-> !p2p_enable && !bus_enable && !bus_reply && !p2p_valid;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("links active while asleep");
   property p_wake_min;
      $rose(asleep) |-> awake_cnt_r >= WAKE_CYC - 2;
   endproperty
   a_wake_min: assert property (p_wake_min)
      else $error("slept before the wake window ran out");
   property p_bus_cause;
      bus_reply |-> $past(bus_req && bus_enable);
   endproperty
   a_bus_cause: assert property (p_bus_cause)
      else $error("bus reply without request");
   property p_p2p_hold;
      p2p_valid && !p2p_ready && p2p_enable |=> p2p_valid || !p2p_enable;
   endproperty
   a_p2p_hold: assert property (p_p2p_hold)
      else $error("pushed result dropped before ready");
   property p_push_cause;
      $rose(p2p_valid) |-> $past(meas_done && echo_found);
   endproperty
   a_push_cause: assert property (p_push_cause)
      else $error("push without accepted echo");
   property p_start_gap;
      (meas_start || cal_start) |=> !(meas_start || cal_start) [*1];
   endproperty
   a_start_gap: assert property (p_start_gap)
      else $error("start inside a running sequence");
   property p_fr_cause;
      $rose(defaults_pending) |-> $past(frst_wr) || $past(frst_wr, 2);
   endproperty
   a_fr_cause: assert property (p_fr_cause)
      else $error("defaults pending without factory reset");
endmodule

// ===== sim/front_end_model.sv
// Behavioural radar front end answering start pulses after a set delay.
// Echo data is qualified by meas_done only; between results it shows junk.
`timescale 1ns/1ps
module front_end_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // From the controller
   input wire logic meas_start,
   input wire logic cal_start,
   // Scenario settings
   input wire logic found_in,
   input wire logic [31:0] dist_in,
   input wire logic [7:0] lat,
   // To the controller
   output logic meas_done,
   output logic cal_done,
   output logic echo_found,
   output logic [31:0] echo_dist
);
   logic busy_r, kind_r;
   logic [7:0] cnt_r;
   always_ff @(posedge aclk) begin
      meas_done <= 1'b0;
      cal_done <= 1'b0;
      if (!aresetn) begin
         busy_r <= 1'b0;
      end else if (meas_start || cal_start) begin
         busy_r <= 1'b1;
         kind_r <= meas_start;
         cnt_r <= lat;
      end else if (busy_r && cnt_r == 8'h00) begin
         busy_r <= 1'b0;
         meas_done <= kind_r;
         cal_done <= !kind_r;
      end else begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   // Not held after the pulse: inverted so stale data never matches the result
   assign echo_found = meas_done ? found_in : !found_in;
   assign echo_dist = meas_done ? dist_in : ~dist_in;
endmodule

// ===== sim/level_sensor_mode_control_tb.sv
// Self-checking bench for the level sensor mode controller.
// One 125 MHz clock; AXI4-Lite master, front-end model and link strobes.
`timescale 1ns/1ps
module level_sensor_mode_control_tb;
   import level_pkg::*;
   localparam longint WAKE = 200;
   logic aclk, aresetn, found_in;
   logic [7:0] s_axi_awaddr, s_axi_araddr, sdi_addr, bus_req_addr, lat;
   logic [31:0] s_axi_wdata, s_axi_rdata, echo_dist, p2p_level, bus_level, dist_in, rd;
   logic [3:0] s_axi_wstrb, level_unit;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bus_req, bus_enable;
   logic meas_start, cal_start, meas_done, echo_found, cal_done, sdi_measure, p2p_connect;
   logic p2p_enable, p2p_valid, p2p_ready, bus_reply, asleep, defaults_pending;
   frame_t p2p_frame, bus_frame;
   int err_total = 0, total_checks = 0, cyc = 0, nm, nc;
   level_sensor_mode_control #(.WAKE_CYC(WAKE), .CAL_SLOW_CYC(100), .CAL_FAST_CYC(20)) dut (.*);
   front_end_model fe (.*);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Whole run needs about 1800 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         err_total++;
         $display("unexpected %0t timeout", $time);
         report_and_stop();
      end
   end
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      #1;
      while (s_axi_awready !== 1'b1) @(posedge aclk) #1;
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      #1;
      while (s_axi_bvalid !== 1'b1) @(posedge aclk) #1;
      rs = s_axi_bresp;
      @(posedge aclk) s_axi_bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      #1;
      while (s_axi_arready !== 1'b1) @(posedge aclk) #1;
      @(posedge aclk) s_axi_arvalid <= 1'b0;
      #1;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk) #1;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk) s_axi_rready <= 1'b0;
   endtask
   task automatic count(input int n);
      nm = 0;
      nc = 0;
      repeat (n) begin
         #1;
         nm += meas_start;
         nc += cal_start;
         @(posedge aclk);
      end
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk(cal_start, 1'b1);
   endtask
   task automatic bus_try(input logic [7:0] id, input logic exp);
      @(posedge aclk);
      bus_req <= 1'b1;
      bus_req_addr <= id;
      @(posedge aclk);
      bus_req <= 1'b0;
      bus_req_addr <= ~id;
      #1;
      chk(bus_reply, exp);
      @(posedge aclk) #1;
      chk(bus_reply, 1'b0);
   endtask
   task automatic sdi_try(input logic [7:0] a, input int exp);
      @(posedge aclk);
      sdi_measure <= 1'b1;
      sdi_addr <= a;
      @(posedge aclk);
      sdi_measure <= 1'b0;
      sdi_addr <= ~a;
      count(60);
      chk(nm, exp);
   endtask
   task automatic t_defaults();
      logic [7:0] ofs [8] = '{CTRL_OFS, ZONE_MIN_OFS, ZONE_MAX_OFS, HEIGHT_OFS, IDS_OFS,
         P2P_BAUD_OFS, BUS_BAUD_OFS, FRAME_OFS};
      logic [31:0] val [8] = '{32'h1, 32'h0, 32'h3a98, 32'h0, 32'h3001, 32'h1_c200,
         32'h2580, 32'h2};
      for (int i = 0; i < 8; i++) begin
         rd_reg(ofs[i]);
         chk(rd, val[i]);
      end
      chk(p2p_frame, {32'h1_c200, 4'h8, PAR_NONE, 1'b0});
      chk(bus_frame, {32'h2580, 4'h8, PAR_EVEN, 1'b0});
      chk(level_unit, UNIT_MM);
      rd_reg(8'h2c);
      chk({rs, rd}, {RESP_SLVERR, 32'h0});
      wr(8'h2c, 32'h0);
      chk(rs, RESP_SLVERR);
      $display("test defaults done");
   endtask
   task automatic t_level();
      logic [31:0] outs [2] = '{32'h1f4, 32'h1b58};
      wr(HEIGHT_OFS, 32'h1388);
      wr(ZONE_MIN_OFS, 32'h3e8);
      wr(ZONE_MAX_OFS, 32'h1770);
      dist_in <= 32'hfa0;
      found_in <= 1'b1;
      #1;
      while (p2p_valid !== 1'b1) @(posedge aclk) #1;
      repeat (20) @(posedge aclk);
      chk(p2p_valid, 1'b1);
      chk(p2p_level, 32'h3e8);
      chk(bus_level, 32'h3e8);
      @(posedge aclk) p2p_ready <= 1'b1;
      @(posedge aclk) p2p_ready <= 1'b0;
      rd_reg(DIST_OFS);
      chk(rd, 32'hfa0);
      for (int i = 0; i < 2; i++) begin
         dist_in <= outs[i];
         repeat (10) @(posedge aclk);
         p2p_ready <= 1'b1;
         repeat (3) @(posedge aclk);
         p2p_ready <= 1'b0;
         repeat (60) @(posedge aclk) #1;
         chk(p2p_valid, 1'b0);
         chk(bus_level, 32'h3e8);
      end
      dist_in <= 32'hfa0;
      $display("test level done");
   endtask
   task automatic t_standby();
      wr(CTRL_OFS, 32'h0);
      repeat (30) @(posedge aclk);
      count(150);
      chk(nm + nc, 0);
      bus_try(8'h01, 1'b1);
      bus_try(8'h02, 1'b0);
      wr(CTRL_OFS, 32'h1);
      count(60);
      chk(nm > 4, 1'b1);
      $display("test standby done");
   endtask
   task automatic t_cal();
      count(500);
      chk(nc >= 4 && nc <= 6, 1'b1);
      wr(CTRL_OFS, 32'h5);
      repeat (40) @(posedge aclk);
      count(200);
      chk(nc >= 9 && nc <= 11, 1'b1);
      $display("test calibration done");
   endtask
   task automatic t_factory();
      wr(FRAME_OFS, 32'h1);
      chk(bus_frame.parity, PAR_ODD);
      wr(CTRL_OFS, 32'h8);
      chk(defaults_pending, 1'b1);
      rd_reg(CTRL_OFS);
      chk(rd, 32'h1);
      rd_reg(HEIGHT_OFS);
      chk(rd, 32'h0);
      rd_reg(FRAME_OFS);
      chk(rd, 32'h1);
      do_reset();
      chk(bus_frame, {32'h2580, 4'h8, PAR_EVEN, 1'b0});
      chk(defaults_pending, 1'b0);
      $display("test factory reset done");
   endtask
   task automatic t_sdi();
      wr(CTRL_OFS, 32'h3);
      repeat (140) @(posedge aclk);
      p2p_connect <= 1'b1;
      @(posedge aclk) p2p_connect <= 1'b0;
      repeat (100) @(posedge aclk) #1;
      chk(asleep, 1'b0);
      for (int i = 0; i < 400 && asleep !== 1'b1; i++) @(posedge aclk) #1;
      chk({asleep, p2p_enable, bus_enable}, 3'b100);
      bus_try(8'h01, 1'b0);
      @(posedge aclk) p2p_connect <= 1'b1;
      @(posedge aclk) p2p_connect <= 1'b0;
      count(100);
      chk({nm, p2p_enable}, 33'h0);
      sdi_try(8'h31, 0);
      sdi_try(8'h30, 1);
      $display("test sdi mode done");
   endtask
   initial begin
      {aresetn, found_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, sdi_measure, p2p_connect, p2p_ready, bus_req} = '0;
      {s_axi_awaddr, s_axi_araddr, sdi_addr, bus_req_addr, s_axi_wdata, dist_in} = '0;
      s_axi_wstrb = 4'hf;
      lat = 8'h4;
      do_reset();
      t_defaults();
      t_level();
      t_standby();
      t_cal();
      t_factory();
      t_sdi();
      report_and_stop();
   end
endmodule
bind level_sensor_mode_control level_sensor_mode_control_props #(.WAKE_CYC(WAKE_CYC)) props (.*);
